// ### rtl/lpm_cfg.svh
// Offsets, field positions, reset values and reset vector pair of the mode block
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
// Register byte offsets
`define LPM_OFF_CTRL 8'h00
`define LPM_OFF_OPTS 8'h04
`define LPM_OFF_GATE1 8'h08
`define LPM_OFF_GATE2 8'h0C
`define LPM_OFF_STAT 8'h10
`define LPM_OFF_VECT 8'h14
// Control register fields
`define LPM_CTRL_LPRREQ 0
`define LPM_CTRL_PPDSEL 1
`define LPM_CTRL_PPDEN 2
`define LPM_CTRL_LVDEN 3
`define LPM_CTRL_LVDSTEN 4
// Option register fields
`define LPM_OPT_STOPEN 0
`define LPM_OPT_DBGEN 1
`define LPM_OPT_IRCEN 2
`define LPM_OPT_IRSTEN 3
`define LPM_OPT_ADCASYNC 4
// Reset values
`define LPM_CTRL_RST 5'h18
`define LPM_OPTS_RST 5'h00
`define LPM_GATE_RST 8'hFF
// Reset vector pair
`define LPM_VEC_HI 16'hFFFE
`define LPM_VEC_LO 16'hFFFF
`endif

// ### rtl/lpm_pkg.sv
// Types shared by the mode controller
package lpm_pkg;
  typedef enum logic [2:0] {
    LPM_RUN    = 3'b000,
    LPM_LOW_POWER_RUN_MODE  = 3'b001,
    LPM_WAIT   = 3'b010,
    LPM_LOW_POWER_WAIT_MODE = 3'b011,
    LPM_LSTOP  = 3'b100,
    LPM_DSTOP  = 3'b101,
    LPM_HOLD   = 3'b110
  } lpm_mode_t;

  typedef enum logic [1:0] {
    LPM_SEL_ILLEGAL = 2'b00,
    LPM_SEL_LIGHT   = 2'b01,
    LPM_SEL_DEEP    = 2'b10
  } lpm_stop_sel_t;
endpackage : lpm_pkg

// ### rtl/lpm_ctrl.sv
// Low power mode controller with AXI4-Lite register slave
`timescale 1ns/1ps
`include "lpm_cfg.svh"

// Summary of operation
// RULE1 - Both select pins high enter run after reset
// RULE2 - Fetch starts from vector pair at top
// RULE3 - Low-power run puts regulator in standby
// RULE4 - Cleared gate bit stops peripheral clock
// RULE5 - Software uses low-power clock, slow bus
// RULE6 - Flash program/erase refused in low-power modes
// RULE7 - Software clocks time-of-day from low clock
// RULE8 - Interrupt or reset ends run/wait low modes
// RULE9 - Wait stops CPU clock, peripherals run
// RULE10 - Wait entry clears interrupt mask bit
// RULE11 - Interrupt wake resumes through stacking sequence
// RULE12 - Wait in low-power run enters low-power wait
// RULE13 - Stop disabled gives illegal-opcode reset; code gives it only from run, stop is ignored in low-power run
// RULE14 - Debug enabled gives light stop, debug alive
// RULE15 - Both detect bits give light stop, regulator
// RULE16 - Otherwise select bit picks light or deep
// RULE17 - Deep stop latches pins, keeps RAM only
// RULE18 - Deep stop left by reset pin, IRQ
// RULE19 - Light stop retains registers, RAM, pins
// RULE20 - Light stop left on listed interrupts
// RULE21 - Reference clock stays on if both enabled
// RULE22 - Converter runs if async clock, detect on
// RULE23 - Software requests low-power run by bit
// RULE24 - Software sets both power-down bits first
// RULE25 - Clock generator resumes prior state after stop
// RULE26 - Mode changes only on instruction, wake, reset
module lpm_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins from outside
  input wire logic background_mode_select_pin,
  input wire logic loader_select_pin,
  input wire logic irq_pin,
  // Core events
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic flash_cmd_req,
  input wire logic [7:0] wake_irq,
  // Core controls
  output logic cpu_clk_en,
  output logic cpu_run,
  output logic clear_int_mask,
  output logic stack_on_wake,
  output logic illegal_op_reset,
  output logic [15:0] fetch_vector,
  output logic flash_cmd_refused,
  // System controls
  output logic reg_standby,
  output logic periph_slow,
  output logic [15:0] periph_clk_en,
  output logic pin_latch,
  output logic core_power_off,
  output logic debug_alive,
  output logic ref_clk_on,
  output logic adc_on,
  output logic clk_gen_stopped,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  lpm_pkg::lpm_mode_t mode, next_mode;
  logic [4:0] ctrl, opts;
  logic [7:0] gate1, gate2, aw_addr;
  logic [2:0] bms_sync, lsel_sync;
  logic [1:0] irq_sync;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic boot_pending, aw_held, w_held, wr_fire, wake_any, low_mode;
  lpm_pkg::lpm_stop_sel_t stop_sel;
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Stop depth decode from option and control bits
  function automatic lpm_pkg::lpm_stop_sel_t sel_stop(
    input logic [4:0] o,
    input logic [4:0] c
  );
    if (!o[`LPM_OPT_STOPEN]) begin
      sel_stop = lpm_pkg::LPM_SEL_ILLEGAL; // RULE13
    end else if (o[`LPM_OPT_DBGEN]) begin
      sel_stop = lpm_pkg::LPM_SEL_LIGHT; // RULE14
    end else if (c[`LPM_CTRL_LVDEN] && c[`LPM_CTRL_LVDSTEN]) begin
      sel_stop = lpm_pkg::LPM_SEL_LIGHT; // RULE15
    end else if (c[`LPM_CTRL_PPDSEL]) begin
      sel_stop = lpm_pkg::LPM_SEL_DEEP; // RULE16
    end else begin
      sel_stop = lpm_pkg::LPM_SEL_LIGHT; // RULE16
    end
  endfunction : sel_stop

  assign stop_sel = sel_stop(opts, ctrl);
  assign wake_any = |wake_irq;
  assign low_mode = (mode == lpm_pkg::LPM_LOW_POWER_RUN_MODE) ||
                    (mode == lpm_pkg::LPM_LOW_POWER_WAIT_MODE);
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Pin synchronisers; third stage lets the strap be caught after release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bms_sync <= 3'h0;
      lsel_sync <= 3'h0;
      irq_sync <= 2'h0;
    end else begin
      bms_sync <= {bms_sync[1:0], background_mode_select_pin};
      lsel_sync <= {lsel_sync[1:0], loader_select_pin};
      irq_sync <= {irq_sync[0], irq_pin};
    end
  end

  // Boot waits until straps have passed the synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_pending <= 1'b1;
    end else if (next_mode == lpm_pkg::LPM_RUN) begin
      boot_pending <= 1'b0;
    end
  end

  // Mode transitions
  always_comb begin
    next_mode = mode;
    unique case (mode)
      lpm_pkg::LPM_HOLD: begin
        if (bms_sync[2] && lsel_sync[2]) begin
          next_mode = lpm_pkg::LPM_RUN; // RULE1
        end
      end
      lpm_pkg::LPM_RUN: begin
        if (stop_exec && stop_sel == lpm_pkg::LPM_SEL_DEEP) begin
          next_mode = lpm_pkg::LPM_DSTOP; // RULE16
        end else if (stop_exec && stop_sel == lpm_pkg::LPM_SEL_LIGHT) begin
          next_mode = lpm_pkg::LPM_LSTOP;
        end else if (wait_exec) begin
          next_mode = lpm_pkg::LPM_WAIT; // RULE9
        end else if (ctrl[`LPM_CTRL_LPRREQ]) begin
          next_mode = lpm_pkg::LPM_LOW_POWER_RUN_MODE;
        end
      end
      lpm_pkg::LPM_LOW_POWER_RUN_MODE: begin
        if (wait_exec) begin
          next_mode = lpm_pkg::LPM_LOW_POWER_WAIT_MODE; // RULE12
        end else if (wake_any || !ctrl[`LPM_CTRL_LPRREQ]) begin
          next_mode = lpm_pkg::LPM_RUN; // RULE8
        end
      end
      lpm_pkg::LPM_WAIT, lpm_pkg::LPM_LOW_POWER_WAIT_MODE: begin
        if (wake_any) begin
          next_mode = lpm_pkg::LPM_RUN; // RULE8
        end
      end
      lpm_pkg::LPM_LSTOP: begin
        if (wake_any || irq_sync[1]) begin
          next_mode = lpm_pkg::LPM_RUN; // RULE20
        end
      end
      lpm_pkg::LPM_DSTOP: begin
        if (irq_sync[1]) begin
          next_mode = lpm_pkg::LPM_RUN; // RULE18
        end
      end
      default: begin
        next_mode = lpm_pkg::LPM_HOLD;
      end
    endcase
  end

  // Mode register; reset pin arrives on rst, illegal-opcode reset on illegal_op_reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= lpm_pkg::LPM_HOLD;
    end else if (illegal_op_reset) begin
      mode <= lpm_pkg::LPM_HOLD; // RULE13
    end else begin
      mode <= next_mode; // RULE26
    end
  end

  // Core-facing pulses and levels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_clk_en <= 1'b0;
      cpu_run <= 1'b0;
      clear_int_mask <= 1'b0;
      stack_on_wake <= 1'b0;
      illegal_op_reset <= 1'b0;
      fetch_vector <= 16'h0000;
    end else begin
      cpu_run <= (next_mode == lpm_pkg::LPM_RUN) ||
                 (next_mode == lpm_pkg::LPM_LOW_POWER_RUN_MODE);
      cpu_clk_en <= (next_mode == lpm_pkg::LPM_RUN) ||
                    (next_mode == lpm_pkg::LPM_LOW_POWER_RUN_MODE); // RULE9
      clear_int_mask <= wait_exec && (mode == lpm_pkg::LPM_RUN ||
                        mode == lpm_pkg::LPM_LOW_POWER_RUN_MODE); // RULE10
      // Wake from wait goes through stacking, never plain resume
      stack_on_wake <= (mode == lpm_pkg::LPM_WAIT ||
                        mode == lpm_pkg::LPM_LOW_POWER_WAIT_MODE) && wake_any; // RULE11
      illegal_op_reset <= stop_exec && mode == lpm_pkg::LPM_RUN &&
                          stop_sel == lpm_pkg::LPM_SEL_ILLEGAL; // RULE13
      if (mode == lpm_pkg::LPM_HOLD) begin
        fetch_vector <= `LPM_VEC_HI; // RULE2
      end
    end
  end

  // Refusal of flash commands in low-power modes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_cmd_refused <= 1'b0;
    end else begin
      flash_cmd_refused <= flash_cmd_req && low_mode; // RULE6
    end
  end

  // Power, clock and retention controls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_standby <= 1'b0;
      periph_slow <= 1'b0;
      pin_latch <= 1'b0;
      core_power_off <= 1'b0;
      debug_alive <= 1'b0;
      ref_clk_on <= 1'b1;
      adc_on <= 1'b1;
      clk_gen_stopped <= 1'b0;
      periph_clk_en <= 16'h0000;
    end else begin
      reg_standby <= (next_mode == lpm_pkg::LPM_LOW_POWER_RUN_MODE) ||
                     (next_mode == lpm_pkg::LPM_LOW_POWER_WAIT_MODE) ||
                     (next_mode == lpm_pkg::LPM_LSTOP &&
                      !(ctrl[`LPM_CTRL_LVDEN] &&
                        ctrl[`LPM_CTRL_LVDSTEN])); // RULE3 RULE15
      periph_slow <= (next_mode == lpm_pkg::LPM_LOW_POWER_WAIT_MODE); // RULE12
      pin_latch <= (next_mode == lpm_pkg::LPM_DSTOP) ||
                   (next_mode == lpm_pkg::LPM_LSTOP); // RULE17 RULE19
      core_power_off <= (next_mode == lpm_pkg::LPM_DSTOP); // RULE17
      debug_alive <= opts[`LPM_OPT_DBGEN] &&
                     next_mode != lpm_pkg::LPM_DSTOP; // RULE14
      // Stop freezes the generator; its settings are kept so exit resumes
      clk_gen_stopped <= (next_mode == lpm_pkg::LPM_LSTOP) ||
                         (next_mode == lpm_pkg::LPM_DSTOP); // RULE25
      if (next_mode == lpm_pkg::LPM_LSTOP) begin
        ref_clk_on <= opts[`LPM_OPT_IRCEN] && opts[`LPM_OPT_IRSTEN]; // RULE21
        adc_on <= opts[`LPM_OPT_ADCASYNC] && ctrl[`LPM_CTRL_LVDEN]; // RULE22
      end else begin
        ref_clk_on <= next_mode != lpm_pkg::LPM_DSTOP;
        adc_on <= next_mode != lpm_pkg::LPM_DSTOP;
      end
      // Codes 0 to 3 are the clocked modes; stop and hold gate everything
      periph_clk_en <= next_mode[2] ? 16'h0000 : {gate2, gate1}; // RULE4
    end
  end

  // Write channel capture; address and data in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= `LPM_OFF_GATE2 && aw_addr[1:0] == 2'h0)
                       ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) &&
                      !s_axi_bvalid;
    end
  end

  // Register writes; gating bits default on so peripherals start clocked
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= `LPM_CTRL_RST;
      opts <= `LPM_OPTS_RST;
      gate1 <= `LPM_GATE_RST;
      gate2 <= `LPM_GATE_RST;
    end else begin
      if (wr_fire && aw_addr == `LPM_OFF_CTRL) begin
        ctrl <= w_strb[0] ? w_data[4:0] : ctrl;
      end else if (low_mode && wake_any) begin
        ctrl[`LPM_CTRL_LPRREQ] <= 1'b0; // RULE8
      end
      if (wr_fire && aw_addr == `LPM_OFF_OPTS) begin
        opts <= w_strb[0] ? w_data[4:0] : opts;
      end
      if (wr_fire && aw_addr == `LPM_OFF_GATE1) begin
        gate1 <= w_strb[0] ? w_data[7:0] : gate1; // RULE4
      end
      if (wr_fire && aw_addr == `LPM_OFF_GATE2) begin
        gate2 <= w_strb[0] ? w_data[7:0] : gate2; // RULE4
      end
    end
  end

  // Read channel, one cycle after address taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          `LPM_OFF_CTRL: s_axi_rdata <= {27'h0, ctrl};
          `LPM_OFF_OPTS: s_axi_rdata <= {27'h0, opts};
          `LPM_OFF_GATE1: s_axi_rdata <= {24'h0, gate1};
          `LPM_OFF_GATE2: s_axi_rdata <= {24'h0, gate2};
          `LPM_OFF_STAT: s_axi_rdata <= {28'h0, boot_pending, mode};
          `LPM_OFF_VECT: s_axi_rdata <= {`LPM_VEC_HI, `LPM_VEC_LO};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Checks on the default clock; raw option bits, not the stop decode
  a_illegal_stop_rst: assert property (stop_exec && // RULE13
    mode == lpm_pkg::LPM_RUN && !opts[`LPM_OPT_STOPEN] |=> illegal_op_reset
    ##1 mode == lpm_pkg::LPM_HOLD) else $error("no illegal opcode reset");
  a_debug_light_stop: assert property (stop_exec && // RULE14
    mode == lpm_pkg::LPM_RUN && opts[1:0] == 2'h3
    |=> mode == lpm_pkg::LPM_LSTOP) else $error("debug stop not light");
  a_deep_stop_sel: assert property (stop_exec && opts[1:0] == 2'h1 && // RULE17
    mode == lpm_pkg::LPM_RUN && !ctrl[`LPM_CTRL_LVDSTEN] &&
    ctrl[`LPM_CTRL_PPDSEL] |=> mode == lpm_pkg::LPM_DSTOP && pin_latch &&
    core_power_off) else $error("deep stop entry wrong");
  a_deep_stop_exit: assert property (mode == lpm_pkg::LPM_DSTOP && // RULE18
    !irq_sync[1] |=> mode == lpm_pkg::LPM_DSTOP) else $error("deep exit");
  a_flash_refuse: assert property (flash_cmd_req && low_mode // RULE6
    |=> flash_cmd_refused) else $error("flash command not refused");
  a_wait_mask_clr: assert property (wait_exec && !stop_exec && // RULE10
    mode == lpm_pkg::LPM_RUN |=> clear_int_mask && !cpu_clk_en &&
    mode == lpm_pkg::LPM_WAIT) else $error("wait entry wrong");
  a_low_power_wait_mode_entry: assert property (wait_exec && // RULE12
    mode == lpm_pkg::LPM_LOW_POWER_RUN_MODE |=> mode == lpm_pkg::LPM_LOW_POWER_WAIT_MODE && reg_standby
    && periph_slow) else $error("low-power wait entry wrong");
  a_wait_wake: assert property (mode == lpm_pkg::LPM_WAIT && wake_any // RULE8
    |=> stack_on_wake && mode == lpm_pkg::LPM_RUN)
    else $error("wait not left on interrupt");
  a_gate_follow: assert property (mode == lpm_pkg::LPM_RUN && // RULE4
    next_mode == lpm_pkg::LPM_RUN |=> periph_clk_en[7:0] == $past(gate1) &&
    periph_clk_en[15:8] == $past(gate2)) else $error("gate not followed");

endmodule : lpm_ctrl

// ### verif/lpm_core_model.sv
// Core model that turns bench requests into instruction pulses
`timescale 1ns/1ps
module lpm_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the bench
  input wire logic req_wait,
  input wire logic req_stop,
  input wire logic req_flash,
  // Core clock gate
  input wire logic cpu_clk_en,
  // Instruction events
  output logic wait_exec,
  output logic stop_exec,
  output logic flash_cmd_req
);
  // A gated core executes nothing, so requests die while unclocked
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_exec <= 1'b0;
      stop_exec <= 1'b0;
      flash_cmd_req <= 1'b0;
    end else begin
      wait_exec <= req_wait & cpu_clk_en;
      stop_exec <= req_stop & cpu_clk_en;
      flash_cmd_req <= req_flash & cpu_clk_en;
    end
  end
endmodule : lpm_core_model

// ### verif/tb_top.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/1ps
`include "lpm_cfg.svh"
module tb_top;
  // Clock, reset, pins and core
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic background_mode_select_pin = 1'b1;
  logic loader_select_pin = 1'b0;
  logic irq_pin = 1'b0;
  logic [7:0] wake_irq = 8'h00;
  logic req_wait = 1'b0;
  logic req_stop = 1'b0;
  logic req_flash = 1'b0;
  logic wait_exec, stop_exec, flash_cmd_req;
  logic cpu_clk_en, cpu_run, clear_int_mask, stack_on_wake;
  logic illegal_op_reset, flash_cmd_refused, reg_standby, periph_slow;
  logic [15:0] fetch_vector, periph_clk_en;
  logic pin_latch, core_power_off, debug_alive, ref_clk_on, adc_on;
  logic clk_gen_stopped;
  // Register bus
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Bookkeeping
  int num_errors = 0;
  int checks = 0;
  int n_cim = 0;
  int n_stk = 0;
  int n_ill = 0;
  int n_ref = 0;
  logic [7:0] st_ctrl [5] = '{8'h18, 8'h18, 8'h18, 8'h08, 8'h06};
  logic [7:0] st_opts [5] = '{8'h00, 8'h03, 8'h1D, 8'h01, 8'h01};

  lpm_ctrl u_dut (.*);
  lpm_core_model u_core (.*);

  // Clock at 200 MHz
  always #2.5 clk_sys = ~clk_sys;

  // Pulse counters; each pulse stands one cycle, so sample every edge
  always @(posedge clk_sys) begin
    if (clear_int_mask === 1'b1) n_cim++;
    if (stack_on_wake === 1'b1) n_stk++;
    if (illegal_op_reset === 1'b1) n_ill++;
    if (flash_cmd_refused === 1'b1) n_ref++;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic tmo;
    num_errors++;
    $display("CHECK FAILED wait limit exp 1 got 0");
    conclude();
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tk

  // Bounded wait for the core to be running again
  task automatic wrun;
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 40) begin
      tk(1);
      n++;
    end
    if (n >= 40) tmo();
  endtask : wrun

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'b1 && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1 && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) tmo();
    chk("bresp", 2'b00, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'b1 && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) tmo();
  endtask : rd

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", 2'b00, r);
  endtask : rdchk

  // Instruction: 0 wait, 1 stop, 2 flash; outputs settle two edges on
  task automatic ins(input int k);
    @(posedge clk_sys);
    req_wait <= (k == 0);
    req_stop <= (k == 1);
    req_flash <= (k == 2);
    @(posedge clk_sys);
    req_wait <= 1'b0;
    req_stop <= 1'b0;
    req_flash <= 1'b0;
    tk(2);
  endtask : ins

  task automatic t_boot;
    logic [31:0] d;
    logic [1:0] r;
    tk(10);
    chk("run without strap", 0, cpu_run);
    @(posedge clk_sys);
    loader_select_pin <= 1'b1;
    wrun();
    chk("vector", 16'hFFFE, fetch_vector);
    rdchk("vect", `LPM_OFF_VECT, 32'hFFFEFFFF);
    rdchk("ctrl", `LPM_OFF_CTRL, 32'h00000018);
    rdchk("gate1", `LPM_OFF_GATE1, 32'h000000FF);
    rd(8'h18, d, r);
    chk("unmapped resp", 2'b10, r);
    $display("test boot done");
  endtask : t_boot

  task automatic t_gate;
    wr(`LPM_OFF_GATE1, 32'h0000005A);
    wr(`LPM_OFF_GATE2, 32'h000000A5);
    tk(2);
    chk("gates", 16'hA55A, periph_clk_en);
    $display("test gate done");
  endtask : t_gate

  task automatic t_wait;
    int c;
    int s;
    c = n_cim;
    s = n_stk;
    ins(0);
    chk("cpu clk", 0, cpu_clk_en);
    chk("periph in wait", 16'hA55A, periph_clk_en);
    chk("gen in wait", 0, clk_gen_stopped);
    chk("mask pulse", c + 1, n_cim);
    @(posedge clk_sys);
    wake_irq <= 8'h80;
    wrun();
    @(posedge clk_sys);
    wake_irq <= 8'h00;
    tk(1);
    chk("stack pulse", s + 1, n_stk);
    $display("test wait done");
  endtask : t_wait

  task automatic t_low_power_run_mode;
    int c;
    // Software has already slowed the bus clock and put time-of-day on
    // its own source; this block sees neither, only the request bit
    wr(`LPM_OFF_CTRL, 32'h00000001);
    tk(2);
    chk("standby", 1, reg_standby);
    c = n_ref;
    ins(2);
    chk("flash refused", c + 1, n_ref);
    ins(0);
    rdchk("stat low_power_wait_mode", `LPM_OFF_STAT, 32'h00000003);
    chk("standby wait", 1, reg_standby);
    chk("slow periph", 1, periph_slow);
    @(posedge clk_sys);
    wake_irq <= 8'h01;
    wrun();
    @(posedge clk_sys);
    wake_irq <= 8'h00;
    tk(3);
    chk("standby off", 0, reg_standby);
    rdchk("request cleared", `LPM_OFF_CTRL, 32'h00000000);
    c = n_ref;
    ins(2);
    chk("flash in run", c, n_ref);
    $display("test low_power_run_mode done");
  endtask : t_low_power_run_mode

  task automatic t_stop;
    int c;
    for (int i = 0; i < 5; i++) begin
      wr(`LPM_OFF_CTRL, {24'h0, st_ctrl[i]});
      wr(`LPM_OFF_OPTS, {24'h0, st_opts[i]});
      c = n_ill;
      ins(1);
      if (i == 0) begin
        chk("illegal pulse", c + 1, n_ill);
        wrun();
      end else if (i == 4) begin
        chk("pin latch", 1, pin_latch);
        chk("power off", 1, core_power_off);
        @(posedge clk_sys);
        wake_irq <= 8'hFF;
        tk(6);
        chk("deep held", 1, pin_latch);
        @(posedge clk_sys);
        wake_irq <= 8'h00;
        irq_pin <= 1'b1;
        wrun();
      end else begin
        rdchk("stat", `LPM_OFF_STAT, 32'h00000004);
        chk("debug", i == 1, debug_alive);
        chk("ref clk", i == 2, ref_clk_on);
        chk("adc", i == 2, adc_on);
        chk("gen stop", 1, clk_gen_stopped);
        if (i == 2) chk("regulator", 0, reg_standby);
        @(posedge clk_sys);
        wake_irq <= 8'h04;
        wrun();
      end
      @(posedge clk_sys);
      wake_irq <= 8'h00;
      irq_pin <= 1'b0;
      tk(4);
      chk("gen back", 0, clk_gen_stopped);
      chk("latch off", 0, pin_latch);
    end
    $display("test stop done");
  endtask : t_stop

  // Main sequence: reset for eight cycles, then each scenario
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_boot();
    t_gate();
    t_wait();
    t_low_power_run_mode();
    t_stop();
    conclude();
  end
endmodule : tb_top
